// ---- pkg/stage2_cfg_pkg.sv ----
// Purpose: Shared constants and types for the stage 2 context bank config block
// Assumes: AHB-Lite word registers, byte offsets within an 8-bit window
// Notes:   Field positions follow the translation control layouts
package stage2_cfg_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_STATUS  = 8'h00;
   localparam logic [7:0] OFS_SYNC    = 8'h04;
   localparam logic [7:0] OFS_TCR     = 8'h08;
   localparam logic [7:0] OFS_BASE_LO = 8'h0C;
   localparam logic [7:0] OFS_BASE_HI = 8'h10;
   localparam logic [7:0] OFS_BANK    = 8'h14;

   // AHB encodings
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic       HRESP_OKAY = 1'h0;

   // Translation control field positions
   localparam int EXT_ADDR_BIT = 31;
   localparam int HD_BIT       = 22;
   localparam int HA_BIT       = 21;
   localparam int PS_HI        = 18;
   localparam int PS_LO        = 16;
   localparam int TG_HI        = 15;
   localparam int TG_LO        = 14;
   localparam int SH_HI        = 13;
   localparam int SH_LO        = 12;
   localparam int OC_HI        = 11;
   localparam int OC_LO        = 10;
   localparam int IC_HI        = 9;
   localparam int IC_LO        = 8;
   localparam int SL_HI        = 7;
   localparam int SL_LO        = 6;
   localparam int RS_LONG_HI   = 5;
   localparam int RS_SHORT_HI  = 3;

   // Masks of writable bits per layout
   localparam logic [31:0] TCR_SHORT_MASK = 32'h0000_3FCF;
   localparam logic [31:0] TCR_LONG_MASK  = 32'h0067_FFFF;

   // Base register limits
   localparam int BASE_TOP     = 47;
   localparam int BASE_NARROW  = 40;
   localparam int BASE_MIN_LOW = 3;

   // Granule codes and sizes in address bits
   localparam logic [1:0] GRAN_4K  = 2'h0;
   localparam logic [1:0] GRAN_64K = 2'h1;
   localparam logic [1:0] GRAN_16K = 2'h2;
   localparam int GRAN_4K_BITS  = 12;
   localparam int GRAN_16K_BITS = 14;
   localparam int GRAN_64K_BITS = 16;

   // Span bases of the region size formula
   localparam int SPAN_SHORT = 32;
   localparam int SPAN_LONG  = 64;

   // Hardware update capability codes
   localparam logic [1:0] CAP_AF_OK = 2'h1;
   localparam logic [1:0] CAP_DB_OK = 2'h2;

   // Decoded configuration handed to the table walker
   typedef struct packed {
      logic        wide;
      logic [1:0]  shareability;
      logic [1:0]  outer_cache;
      logic [1:0]  inner_cache;
      logic [1:0]  start_level;
      logic [1:0]  granule;
      logic [6:0]  region_log2;
      logic [5:0]  pa_bits;
      logic        hw_access;
      logic        hw_dirty;
      logic [5:0]  base_low;
      logic [47:0] base;
   } walk_cfg_t;

   // Captured AHB address phase
   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
   } ahb_phase_t;

endpackage : stage2_cfg_pkg

// ---- rtl/stage2_context_translation_cfg.sv ----
// Purpose: Stage 2 context bank registers: TLB sync, translation control, base
// Assumes: Invalidate strobes come from same-clock logic and complete in order
// Notes:   Capability inputs are static straps on the same clock
//
// The AHB-Lite slave port and the placing of the registers were decided locally.

module stage2_context_translation_cfg
   import stage2_cfg_pkg::*;
#(
   parameter int CNT_W = 8
) (
   input  wire logic        i_clock,
   input  wire logic        i_sys_rst,
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   output logic      [31:0] o_hrdata,
   output logic             o_hreadyout,
   output logic             o_hresp,
   input  wire logic        i_inval_accept,
   input  wire logic        i_inval_done,
   input  wire logic [1:0]  i_hw_update_capability,
   input  wire logic [5:0]  i_output_size_capability,
   input  wire logic        i_walk_check,
   input  wire logic [47:0] i_walk_pa,
   output walk_cfg_t        o_walk_cfg,
   output logic             o_sync_active,
   output logic             o_addr_size_fault,
   output logic             o_trans_fault
);

   // Refuse counter widths below 1 or above 16
   if (CNT_W < 1 || CNT_W > 16) begin : g_bad_width
      $error("CNT_W must lie between 1 and 16");
   end

   typedef struct packed {
      ahb_phase_t       ph;
      logic [31:0]      rdata;
      logic [31:0]      tcr;
      logic [47:0]      base;
      logic             wide;
      logic [CNT_W-1:0] pend;
      logic [CNT_W-1:0] snap;
      logic             size_fault;
      logic             xlat_fault;
      walk_cfg_t        cfg;
   } state_t;

   state_t st_reg;
   state_t st_next;

   // Write, read, decode and fault logic
   always_comb begin
      logic             wr_hit;
      logic [31:0]      wmask;
      logic [31:0]      wval;
      logic [31:0]      tcr_view;
      logic [31:0]      rd;
      logic [1:0]       gran;
      logic [1:0]       lvl;
      logic [6:0]       rlog;
      logic [5:0]       pab;
      int               gbits;
      int               after;
      int               low;
      logic             over;
      logic [47:0]      bmask;
      logic [CNT_W-1:0] one;
      wr_hit   = 1'b0;
      wmask    = '0;
      wval     = '0;
      tcr_view = '0;
      rd       = '0;
      gran     = GRAN_4K;
      lvl      = '0;
      rlog     = '0;
      pab      = '0;
      gbits    = GRAN_4K_BITS;
      after    = 0;
      low      = BASE_MIN_LOW;
      over     = 1'b0;
      bmask    = '0;
      one      = CNT_W'(1);
      st_next  = st_reg;

      // Data phase of a captured write
      wr_hit = st_reg.ph.wr;
      if (wr_hit) begin
         unique case (st_reg.ph.addr)
            OFS_TCR: begin
               wmask = st_reg.wide ? TCR_LONG_MASK : TCR_SHORT_MASK;
               wval  = i_hwdata & wmask;
               if (st_reg.wide) begin
                  if (i_hw_update_capability < CAP_AF_OK) begin
                     wval[HA_BIT] = 1'b0;
                  end
                  if (i_hw_update_capability < CAP_DB_OK) begin
                     wval[HD_BIT] = 1'b0;
                  end
               end
               st_next.tcr = (st_reg.tcr & ~wmask) | wval;
            end
            OFS_BASE_LO: st_next.base[31:0] = i_hwdata;
            OFS_BASE_HI: st_next.base[BASE_TOP:32] = i_hwdata[BASE_TOP-32:0];
            OFS_BANK:    st_next.wide = i_hwdata[0];
            default: begin
               // Status, sync trigger and holes store nothing
            end
         endcase
      end

      // Invalidates outstanding in this bank
      st_next.pend = st_reg.pend + CNT_W'(i_inval_accept) - CNT_W'(i_inval_done);

      // Sync snapshot of earlier invalidates, drained in order
      if (wr_hit && st_reg.ph.addr == OFS_SYNC) begin
         st_next.snap = st_reg.pend + CNT_W'(i_inval_accept)
                        - CNT_W'(i_inval_done);
      end else if (i_inval_done && st_reg.snap != '0) begin
         st_next.snap = st_reg.snap - one;
      end

      // Read-back view of the control register
      if (st_next.wide) begin
         tcr_view = st_next.tcr & TCR_LONG_MASK;
      end else begin
         tcr_view = st_next.tcr & TCR_SHORT_MASK;
         tcr_view[EXT_ADDR_BIT] = 1'b1;
      end

      // Address phase: capture and prepare read data
      st_next.ph.wr = 1'b0;
      if (i_hsel && i_htrans[1] && i_hready) begin
         st_next.ph.addr = i_haddr[7:0];
         st_next.ph.wr   = i_hwrite && i_hsize == HSIZE_WORD;
         if (!i_hwrite) begin
            unique case (i_haddr[7:0])
               OFS_STATUS:  rd = {31'h0, st_next.snap != '0};
               OFS_SYNC:    rd = '0;
               OFS_TCR:     rd = tcr_view;
               OFS_BASE_LO: rd = st_next.base[31:0];
               OFS_BASE_HI: rd = {16'h0, st_next.base[BASE_TOP:32]};
               OFS_BANK:    rd = {31'h0, st_next.wide};
               default:     rd = '0;
            endcase
            st_next.rdata = rd;
         end
      end

      // Granule decode with fallback for the reserved code
      unique case (st_next.tcr[TG_HI:TG_LO])
         GRAN_64K: begin
            gran  = GRAN_64K;
            gbits = GRAN_64K_BITS;
         end
         GRAN_16K: begin
            gran  = GRAN_16K;
            gbits = GRAN_16K_BITS;
         end
         default: begin
            gran  = GRAN_4K;
            gbits = GRAN_4K_BITS;
         end
      endcase
      if (!st_next.wide) begin
         gran  = GRAN_4K;
         gbits = GRAN_4K_BITS;
      end

      // Start level decode
      if (!st_next.wide) begin
         lvl = (st_next.tcr[SL_HI:SL_LO] == 2'h0) ? 2'h2 : 2'h1;
      end else if (gran == GRAN_4K) begin
         unique case (st_next.tcr[SL_HI:SL_LO])
            2'h0:    lvl = 2'h2;
            2'h1:    lvl = 2'h1;
            default: lvl = 2'h0;
         endcase
      end else begin
         unique case (st_next.tcr[SL_HI:SL_LO])
            2'h0:    lvl = 2'h3;
            2'h1:    lvl = 2'h2;
            default: lvl = 2'h1;
         endcase
      end

      // Region span as a power of two
      if (st_next.wide) begin
         rlog = 7'(SPAN_LONG - int'($signed(st_next.tcr[RS_LONG_HI:0])));
      end else begin
         rlog = 7'(SPAN_SHORT - int'($signed(st_next.tcr[RS_SHORT_HI:0])));
      end

      // Physical size decode
      unique case (st_next.tcr[PS_HI:PS_LO])
         3'h0:    pab = 6'd32;
         3'h1:    pab = 6'd36;
         3'h2:    pab = 6'd40;
         3'h3:    pab = 6'd42;
         3'h4:    pab = 6'd44;
         default: pab = 6'd48;
      endcase
      if (!st_next.wide) begin
         pab = 6'd48;
      end

      // Lowest base bit from region size, level and granule
      after = gbits + (3 - int'(lvl)) * (gbits - 3);
      low   = int'(rlog) - after + 3;
      if (low < BASE_MIN_LOW) begin
         low = BASE_MIN_LOW;
      end
      if (low > BASE_TOP) begin
         low = BASE_TOP;
      end
      for (int i = 0; i <= BASE_TOP; i++) begin
         bmask[i] = (i >= low) && (st_next.wide || i < BASE_NARROW);
      end

      // Decoded configuration for the walker
      st_next.cfg.wide         = st_next.wide;
      st_next.cfg.shareability = st_next.tcr[SH_HI:SH_LO];
      st_next.cfg.outer_cache  = st_next.tcr[OC_HI:OC_LO];
      st_next.cfg.inner_cache  = st_next.tcr[IC_HI:IC_LO];
      st_next.cfg.start_level  = lvl;
      st_next.cfg.granule      = gran;
      st_next.cfg.region_log2  = rlog;
      st_next.cfg.pa_bits      = pab;
      st_next.cfg.hw_access    = st_next.wide && st_next.tcr[HA_BIT];
      st_next.cfg.hw_dirty     = st_next.wide && st_next.tcr[HA_BIT]
                                 && st_next.tcr[HD_BIT];
      st_next.cfg.base_low     = 6'(low);
      st_next.cfg.base         = st_next.base & bmask;

      // Output address size check against capability
      for (int i = 0; i <= BASE_TOP; i++) begin
         if (i >= int'(i_output_size_capability) && i_walk_pa[i]) begin
            over = 1'b1;
         end
      end
      st_next.size_fault = i_walk_check && over && st_reg.wide;
      st_next.xlat_fault = i_walk_check && over && !st_reg.wide;

      // Synchronous reset to defined values
      if (i_sys_rst) begin
         st_next = '0;
      end
   end

   // State register
   always_ff @(posedge i_clock) begin
      st_reg <= st_next;
   end

   // Bus answers and walker outputs
   assign o_hrdata          = st_reg.rdata;
   assign o_hreadyout       = 1'b1;
   assign o_hresp           = HRESP_OKAY;
   assign o_walk_cfg        = st_reg.cfg;
   assign o_sync_active     = st_reg.snap != '0;
   assign o_addr_size_fault = st_reg.size_fault;
   assign o_trans_fault     = st_reg.xlat_fault;

endmodule : stage2_context_translation_cfg

// ---- testbench/stage2_cfg_checker.sv ----
// Purpose: Port-level assertions for the stage 2 config block
// Assumes: One clock, synchronous reset
// Notes:   Bound into every instance of the block
module stage2_cfg_checker
   import stage2_cfg_pkg::*;
(
   input wire logic        i_clock,
   input wire logic        i_sys_rst,
   input wire logic        i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0]  i_htrans,
   input wire logic        i_hwrite,
   input wire logic        i_hready,
   input wire logic        i_inval_done,
   input wire logic [1:0]  i_hw_update_capability,
   input wire logic [5:0]  i_output_size_capability,
   input wire logic        i_walk_check,
   input wire logic [47:0] i_walk_pa,
   input wire walk_cfg_t   o_walk_cfg,
   input wire logic        o_sync_active,
   input wire logic        o_addr_size_fault,
   input wire logic        o_trans_fault
);
   logic sync_dp_reg;
   // Marks a sync trigger write in its data phase
   always_ff @(posedge i_clock) begin
      sync_dp_reg <= !i_sys_rst && i_hsel && i_htrans[1] && i_hready && i_hwrite
                     && i_haddr[7:0] == OFS_SYNC;
   end
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);
   sequence s_sync_wr;
      sync_dp_reg;
   endsequence
   // Sync flag transitions and hold
   a_sync_set_cause: assert property ($rose(o_sync_active) |-> $past(sync_dp_reg))
      else $error("sync flag rose without a sync write");
   a_sync_idle_stay: assert property (s_sync_wr ##1 !o_sync_active ##1 !i_inval_done
      |-> !o_sync_active) else $error("sync flag set without a new sync write");
   a_sync_clear_cause: assert property ($fell(o_sync_active) |->
      $past(i_inval_done) || $past(sync_dp_reg)) else $error("sync flag fell early");
   a_sync_hold: assert property (o_sync_active && !i_inval_done && !sync_dp_reg
      |=> o_sync_active) else $error("sync flag dropped while pending");
   // Fault outputs
   a_fault_scheme: assert property (i_walk_check && (i_walk_pa >> i_output_size_capability) != 0
      |=> o_addr_size_fault == $past(o_walk_cfg.wide) && o_trans_fault == !$past(o_walk_cfg.wide))
      else $error("oversize address fault wrong");
   a_fault_quiet: assert property (!i_walk_check |=> !o_addr_size_fault && !o_trans_fault)
      else $error("fault without a check");
   // Decoded configuration limits
   a_narrow_base: assert property (!o_walk_cfg.wide |-> o_walk_cfg.base[47:40] == 8'h00)
      else $error("narrow base top bits not zero");
   a_short_granule: assert property (!o_walk_cfg.wide |-> o_walk_cfg.granule == GRAN_4K)
      else $error("short layout granule not 4KB");
   a_access_cap: assert property (o_walk_cfg.hw_access |-> i_hw_update_capability != 2'h0)
      else $error("access update without capability");
endmodule : stage2_cfg_checker

bind stage2_context_translation_cfg stage2_cfg_checker u_chk (.i_clock(i_clock),
   .i_sys_rst(i_sys_rst), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
   .i_hwrite(i_hwrite), .i_hready(i_hready), .i_inval_done(i_inval_done),
   .i_hw_update_capability(i_hw_update_capability), .i_walk_check(i_walk_check),
   .i_output_size_capability(i_output_size_capability), .i_walk_pa(i_walk_pa),
   .o_walk_cfg(o_walk_cfg), .o_sync_active(o_sync_active),
   .o_addr_size_fault(o_addr_size_fault), .o_trans_fault(o_trans_fault));

// ---- testbench/stage2_context_translation_cfg_bench.sv ----
// Purpose: Directed bench for the stage 2 config block
// Assumes: Zero-wait AHB slave, same-clock invalidate strobes
// Notes:   Capabilities stay static for the whole run
module stage2_context_translation_cfg_bench
   import stage2_cfg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 0, rst = 1, hsel = 0, hwrite = 0, acc = 0, done = 0, chk = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   logic [1:0]  htrans = 0, cap = 2'h1;
   logic [5:0]  osz = 6'h28;
   logic [47:0] pa = 0;
   logic        ready, resp, active, afault, tfault;
   walk_cfg_t   cfg;
   int          miscompares = 0, comparisons = 0, cycles = 0;

   stage2_context_translation_cfg DUT (.i_clock(clk), .i_sys_rst(rst), .i_hsel(hsel),
      .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(HSIZE_WORD),
      .i_hwdata(hwdata), .i_hready(ready), .o_hrdata(hrdata), .o_hreadyout(ready),
      .o_hresp(resp), .i_inval_accept(acc), .i_inval_done(done),
      .i_hw_update_capability(cap), .i_output_size_capability(osz), .i_walk_check(chk),
      .i_walk_pa(pa), .o_walk_cfg(cfg), .o_sync_active(active),
      .o_addr_size_fault(afault), .o_trans_fault(tfault));

   // Clock and hang guard
   always #2 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         final_report();
      end
   end

   task automatic final_report();
      $display("Counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : final_report

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   // One single AHB transfer, read data kept in rd
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      hsel <= 1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      @(posedge clk);
      while (ready !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (ready !== 1'b1) @(posedge clk);
      rd = hrdata;
      #1;
   endtask : bus

   task automatic strobe(input logic a, input logic d);
      acc <= a;
      done <= d;
      @(posedge clk);
      acc <= 0;
      done <= 0;
      @(posedge clk);
      #1;
   endtask : strobe

   task automatic walk(input logic [47:0] p, input logic af, input logic tf);
      pa <= p;
      chk <= 1;
      @(posedge clk);
      chk <= 0;
      #1;
      check("addr_fault", {31'h0, af}, {31'h0, afault});
      check("trans_fault", {31'h0, tf}, {31'h0, tfault});
      @(posedge clk);
   endtask : walk

   task automatic test_short();
      bus(OFS_TCR, 0, 0);
      check("tcr_reset", 32'h8000_0000, rd);
      check("hresp", 32'(HRESP_OKAY), 32'(resp));
      bus(OFS_TCR, 1, 32'hFFFF_3F5F);
      bus(OFS_TCR, 0, 0);
      check("tcr_short", 32'h8000_3F4F, rd);
      check("attrs", 32'h3F, 32'({cfg.shareability, cfg.outer_cache, cfg.inner_cache}));
      check("level", 32'h1, 32'(cfg.start_level));
      check("region", 32'h21, 32'(cfg.region_log2));
      bus(8'h20, 0, 0);
      check("unmapped", 32'h0, rd);
      $display("test short done");
   endtask : test_short

   task automatic test_wide();
      bus(OFS_BANK, 1, 1);
      bus(OFS_TCR, 1, 32'hFFFF_FFFF);
      bus(OFS_TCR, 0, 0);
      check("tcr_long", 32'h0027_FFFF, rd);
      check("pa_rsvd", 32'h30, 32'(cfg.pa_bits));
      check("region", 32'h41, 32'(cfg.region_log2));
      check("dirty", 32'h0, 32'(cfg.hw_dirty));
      check("access", 32'h1, 32'(cfg.hw_access));
      bus(OFS_TCR, 1, 32'h0000_4080);
      check("granule", 32'h1, 32'(cfg.granule));
      check("level", 32'h1, 32'(cfg.start_level));
      check("pa_min", 32'h20, 32'(cfg.pa_bits));
      bus(OFS_BASE_HI, 1, 32'hFFFF_FFFF);
      bus(OFS_BASE_HI, 0, 0);
      check("base_hi", 32'h0000_FFFF, rd);
      $display("test wide done");
   endtask : test_wide

   task automatic test_sync();
      bus(OFS_STATUS, 1, 1);
      bus(OFS_STATUS, 0, 0);
      check("status_ro", 32'h0, rd);
      bus(OFS_SYNC, 0, 0);
      check("sync_read", 32'h0, rd);
      strobe(1, 0);
      strobe(1, 0);
      bus(OFS_SYNC, 1, 0);
      check("active_set", 32'h1, 32'(active));
      strobe(1, 1);
      check("active_hold", 32'h1, 32'(active));
      strobe(0, 1);
      check("active_clear", 32'h0, 32'(active));
      bus(OFS_STATUS, 0, 0);
      check("status", 32'h0, rd);
      strobe(0, 1);
      $display("test sync done");
   endtask : test_sync

   task automatic test_fault();
      walk(48'h0100_0000_0000, 1, 0);
      walk(48'h00FF_FFFF_FFFF, 0, 0);
      bus(OFS_BANK, 1, 0);
      check("base_top", 32'h0, 32'(cfg.base[47:40]));
      walk(48'h8000_0000_0000, 0, 1);
      $display("test fault done");
   endtask : test_fault

   // Main sequence
   initial begin
      repeat (5) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      bus(OFS_STATUS, 0, 0);
      check("status_reset", 32'h0, rd);
      test_short();
      test_wide();
      test_sync();
      test_fault();
      final_report();
   end
endmodule : stage2_context_translation_cfg_bench
